// [rtl/parity_guard.v]
// Purpose: parity protection of the processor's internal caches, translation buffer and
//          branch target store, plus bus exceptions from uncorrectable memory errors
// Assumes: all inputs but i_arst_n are on i_sys_clk; memory controller does its own ECC
// Notes:   lookups answer one cycle after the request strobe
//
// Summary of operation
// - with fault_protect_cfg set, check internal RAM parity and accept controller errors.
// - check parity on each cache hit; mismatch invalidates the line for refetch.
// - with protection configured, data cache is write-through only.
// - on cache writes store parity: one tag bit, icache data bit, bit per dcache word.
// - translation parity mismatch during lookup raises a translation miss exception.
// - software write of a translation entry stores one parity bit for it.
// - software read of a translation entry checks parity, clears valid on mismatch.
// - bad parity on branch target lookup discards the prediction.
// - each stored branch target gets one parity bit.
// - internal parity stays active even if controller ECC is off.
// - with exception enable set, uncorrectable errors raise instruction or data bus exception.
// - bus exception during exception handling halts and asserts the halt error output.
`timescale 1ns/100ps
`include "parity_guard_map.vh"

module parity_guard #(
  parameter FAULT_PROTECT_CFG = 1,
  parameter IDX_W             = 3,
  parameter TAG_W             = 16,
  parameter IW                = 32,
  parameter WORDS             = 4,
  parameter WSEL_W            = 2,
  parameter DW                = 32,
  parameter TIDX_W            = 3,
  parameter VPN_W             = 20,
  parameter RPN_W             = 20,
  parameter BIDX_W            = 3,
  parameter BT_W              = 30
) (
  input  wire                i_sys_clk,
  input  wire                i_arst_n,
  input  wire [7:0]          i_addr,
  input  wire [31:0]         i_wdata,
  input  wire                i_wr,
  input  wire                i_rd,
  output reg  [31:0]         o_rdata,
  output wire                o_irq,
  input  wire                i_ic_fill,
  input  wire                i_ic_look,
  input  wire [IDX_W-1:0]    i_ic_idx,
  input  wire [TAG_W-1:0]    i_ic_tag,
  input  wire [IW-1:0]       i_ic_data,
  output reg                 o_ic_hit,
  output reg  [IW-1:0]       o_ic_data,
  input  wire                i_dc_fill,
  input  wire                i_dc_store,
  input  wire                i_dc_look,
  input  wire [IDX_W-1:0]    i_dc_idx,
  input  wire [TAG_W-1:0]    i_dc_tag,
  input  wire [WSEL_W-1:0]   i_dc_word,
  input  wire [DW-1:0]       i_dc_wdata,
  input  wire [WORDS*DW-1:0] i_dc_line,
  output reg                 o_dc_hit,
  output reg  [DW-1:0]       o_dc_data,
  output wire                o_dc_writeback,
  input  wire                i_tl_look,
  input  wire [TIDX_W-1:0]   i_tl_idx,
  input  wire [VPN_W-1:0]    i_tl_vpn,
  output reg                 o_tl_hit,
  output reg  [RPN_W-1:0]    o_tl_rpn,
  output reg                 o_tl_miss_exc,
  input  wire                i_bt_wr,
  input  wire                i_bt_look,
  input  wire [BIDX_W-1:0]   i_bt_idx,
  input  wire [BT_W-1:0]     i_bt_target,
  output reg                 o_bt_valid,
  output reg  [BT_W-1:0]     o_bt_target,
  input  wire                i_ibus_ue,
  input  wire                i_dbus_ue,
  input  wire                i_exc_busy,
  output reg                 o_ibus_exc,
  output reg                 o_dbus_exc,
  output wire                o_halt_error_output
);

  localparam LINES  = 1 << IDX_W;
  localparam TLB_N  = 1 << TIDX_W;
  localparam BT_N   = 1 << BIDX_W;
  // parity logic folds away when protection is not configured
  localparam [0:0] FT = (FAULT_PROTECT_CFG != 0);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg  [TAG_W-1:0]    ic_tag_r  [0:LINES-1];
  reg  [IW-1:0]       ic_dat_r  [0:LINES-1];
  reg  [LINES-1:0]    ic_tpar_r;
  reg  [LINES-1:0]    ic_dpar_r;
  reg  [LINES-1:0]    ic_val_r;
  reg  [TAG_W-1:0]    dc_tag_r  [0:LINES-1];
  reg  [WORDS*DW-1:0] dc_line_r [0:LINES-1];
  reg  [WORDS-1:0]    dc_par_r  [0:LINES-1];
  reg  [LINES-1:0]    dc_tpar_r;
  reg  [LINES-1:0]    dc_val_r;
  reg  [VPN_W-1:0]    tl_vpn_r  [0:TLB_N-1];
  reg  [RPN_W-1:0]    tl_rpn_r  [0:TLB_N-1];
  reg  [TLB_N-1:0]    tl_par_r;
  reg  [TLB_N-1:0]    tl_val_r;
  reg  [BT_W-1:0]     bt_tgt_r  [0:BT_N-1];
  reg  [BT_N-1:0]     bt_par_r;
  reg  [BT_N-1:0]     bt_val_r;

  reg  [1:0]          ctrl_r;
  reg  [`EV_W-1:0]    status_r;
  reg  [`EV_W-1:0]    mask_r;
  reg  [31:0]         translation_upper_reg_r;
  reg  [31:0]         translation_lower_reg_r;
  reg  [TIDX_W-1:0]   xl_index_r;
  reg                 halt_r;

  // ----------------------------------------------------------------
  // instruction cache checks
  // ----------------------------------------------------------------
  wire ic_cand = ic_val_r[i_ic_idx] & (ic_tag_r[i_ic_idx] == i_ic_tag);
  // parity checked on hit, tag and data
  wire ic_perr = FT & ic_cand &
                 ((^ic_tag_r[i_ic_idx]) ^ ic_tpar_r[i_ic_idx] | (^ic_dat_r[i_ic_idx]) ^ ic_dpar_r[i_ic_idx]);
  wire ic_ev   = i_ic_look & ic_perr;

  // ----------------------------------------------------------------
  // data cache checks and write source
  // ----------------------------------------------------------------
  wire [WORDS*DW-1:0] dc_cur  = dc_line_r[i_dc_idx];
  wire [WORDS-1:0]    dc_pcur = dc_par_r[i_dc_idx];
  wire [WORDS-1:0]    dc_werr;
  wire [WORDS-1:0]    dc_gpar;
  reg  [WORDS*DW-1:0] dc_src;
  reg  [WORDS-1:0]    dc_pnew;
  wire dc_cand  = dc_val_r[i_dc_idx] & (dc_tag_r[i_dc_idx] == i_dc_tag);
  wire dc_terr  = (^dc_tag_r[i_dc_idx]) ^ dc_tpar_r[i_dc_idx];
  // only the tag parity and the addressed word's parity matter on a hit
  wire dc_perr  = FT & dc_cand & (dc_terr | dc_werr[i_dc_word]);
  wire dc_ev    = i_dc_look & dc_perr;
  // write-through only; a store updates the cached copy on a hit
  wire dc_upd   = i_dc_store & dc_cand & ~i_dc_fill;

  always @* begin
    dc_src  = i_dc_fill ? i_dc_line : dc_cur;
    dc_pnew = dc_pcur;
    if (!i_dc_fill) begin
      dc_src[i_dc_word*DW +: DW] = i_dc_wdata;
    end
    // a store refreshes only its word's bit so others keep their check value
    if (i_dc_fill) begin
      dc_pnew = dc_gpar;
    end else begin
      dc_pnew[i_dc_word] = dc_gpar[i_dc_word];
    end
  end

  parity_line #(.WORDS(WORDS), .DW(DW)) u_dc_gen (
    .i_line (dc_src),
    .i_par  ({WORDS{1'b0}}),
    .o_par  (dc_gpar),
    .o_err  ()
  );

  // same even parity circuit for checking
  parity_line #(.WORDS(WORDS), .DW(DW)) u_dc_chk (
    .i_line (dc_cur),
    .i_par  (dc_pcur),
    .o_par  (),
    .o_err  (dc_werr)
  );

  // write-back request is refused while protection is configured
  assign o_dc_writeback = ctrl_r[`CTRL_WB_REQ_BIT] & ~FT;

  // ----------------------------------------------------------------
  // translation buffer checks
  // ----------------------------------------------------------------
  wire tl_sw_wr = i_wr & (i_addr == `OFS_XLATE_CMD) & i_wdata[`CMD_WRITE_BIT];
  wire tl_sw_rd = i_wr & (i_addr == `OFS_XLATE_CMD) & i_wdata[`CMD_READ_BIT] & ~i_wdata[`CMD_WRITE_BIT];
  wire tl_rperr = FT & ((^{tl_vpn_r[xl_index_r], tl_rpn_r[xl_index_r]}) ^ tl_par_r[xl_index_r]);
  wire tl_lperr = FT & tl_val_r[i_tl_idx] & ((^{tl_vpn_r[i_tl_idx], tl_rpn_r[i_tl_idx]}) ^ tl_par_r[i_tl_idx]);
  wire tl_cand  = tl_val_r[i_tl_idx] & (tl_vpn_r[i_tl_idx] == i_tl_vpn);
  wire tl_ev    = (i_tl_look & tl_lperr) | (tl_sw_rd & tl_val_r[xl_index_r] & tl_rperr);

  // ----------------------------------------------------------------
  // branch target store checks
  // ----------------------------------------------------------------
  wire bt_perr = FT & bt_val_r[i_bt_idx] & ((^bt_tgt_r[i_bt_idx]) ^ bt_par_r[i_bt_idx]);
  wire bt_ev   = i_bt_look & bt_perr;

  // ----------------------------------------------------------------
  // bus exceptions from the memory controller
  // ----------------------------------------------------------------
  // uncorrectable errors only trap with the exception enable bit set
  wire trap_en = ctrl_r[`CTRL_TRAP_BIT];
  wire ibus_ue = FT & trap_en & i_ibus_ue & ~halt_r;
  wire dbus_ue = FT & trap_en & i_dbus_ue & ~halt_r;
  // a nested bus exception cannot be handled safely, so stop instead
  wire halt_ev = (ibus_ue | dbus_ue) & i_exc_busy;

  assign o_halt_error_output = halt_r;

  // ----------------------------------------------------------------
  // array contents (no reset; valid bits guard them)
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    // tag and data parity written with every fill
    if (i_ic_fill) begin
      ic_tag_r[i_ic_idx]  <= i_ic_tag;
      ic_dat_r[i_ic_idx]  <= i_ic_data;
      ic_tpar_r[i_ic_idx] <= ^i_ic_tag;
      ic_dpar_r[i_ic_idx] <= ^i_ic_data;
    end
    if (i_dc_fill | dc_upd) begin
      dc_line_r[i_dc_idx] <= dc_src;
      dc_par_r[i_dc_idx]  <= dc_pnew;
    end
    if (i_dc_fill) begin
      dc_tag_r[i_dc_idx]  <= i_dc_tag;
      dc_tpar_r[i_dc_idx] <= ^i_dc_tag;
    end
    // one parity bit per entry on software write
    if (tl_sw_wr) begin
      tl_vpn_r[xl_index_r] <= translation_upper_reg_r[VPN_W-1:0];
      tl_rpn_r[xl_index_r] <= translation_lower_reg_r[RPN_W-1:0];
      tl_par_r[xl_index_r] <= ^{translation_upper_reg_r[VPN_W-1:0], translation_lower_reg_r[RPN_W-1:0]};
    end
    // parity stored beside each branch target
    if (i_bt_wr) begin
      bt_tgt_r[i_bt_idx] <= i_bt_target;
      bt_par_r[i_bt_idx] <= ^i_bt_target;
    end
  end

  // ----------------------------------------------------------------
  // valid bits and lookup answers
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ic_val_r      <= {LINES{1'b0}};
      dc_val_r      <= {LINES{1'b0}};
      tl_val_r      <= {TLB_N{1'b0}};
      bt_val_r      <= {BT_N{1'b0}};
      o_ic_hit      <= 1'b0;
      o_ic_data     <= {IW{1'b0}};
      o_dc_hit      <= 1'b0;
      o_dc_data     <= {DW{1'b0}};
      o_tl_hit      <= 1'b0;
      o_tl_rpn      <= {RPN_W{1'b0}};
      o_tl_miss_exc <= 1'b0;
      o_bt_valid    <= 1'b0;
      o_bt_target   <= {BT_W{1'b0}};
      o_ibus_exc    <= 1'b0;
      o_dbus_exc    <= 1'b0;
      halt_r        <= 1'b0;
    end else begin
      // bad line dropped so the next access refetches it
      if (i_ic_fill) begin
        ic_val_r[i_ic_idx] <= 1'b1;
      end else if (ic_ev) begin
        ic_val_r[i_ic_idx] <= 1'b0;
      end
      if (i_dc_fill) begin
        dc_val_r[i_dc_idx] <= 1'b1;
      end else if (dc_ev) begin
        dc_val_r[i_dc_idx] <= 1'b0;
      end
      // a software read that finds bad parity invalidates the entry
      if (tl_sw_wr) begin
        tl_val_r[xl_index_r] <= translation_upper_reg_r[`UPPER_VALID_BIT];
      end else if (tl_sw_rd & tl_rperr) begin
        tl_val_r[xl_index_r] <= 1'b0;
      end
      if (i_bt_wr) begin
        bt_val_r[i_bt_idx] <= 1'b1;
      end
      o_ic_hit      <= i_ic_look & ic_cand & ~ic_perr;
      o_ic_data     <= ic_dat_r[i_ic_idx];
      o_dc_hit      <= i_dc_look & dc_cand & ~dc_perr;
      o_dc_data     <= dc_cur[i_dc_word*DW +: DW];
      // a corrupted entry reads as a miss so software reloads it
      o_tl_hit      <= i_tl_look & tl_cand & ~tl_lperr;
      o_tl_miss_exc <= i_tl_look & ~(tl_cand & ~tl_lperr);
      o_tl_rpn      <= tl_rpn_r[i_tl_idx];
      o_bt_valid    <= i_bt_look & bt_val_r[i_bt_idx] & ~bt_perr;
      o_bt_target   <= bt_tgt_r[i_bt_idx];
      // route by the interface that reported the error
      o_ibus_exc    <= ibus_ue & ~i_exc_busy;
      o_dbus_exc    <= dbus_ue & ~i_exc_busy;
      if (halt_ev) begin
        halt_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  wire [`EV_W-1:0] ev_now;
  wire [`EV_W-1:0] st_clr = (i_wr && i_addr == `OFS_STATUS) ? i_wdata[`EV_W-1:0] : {`EV_W{1'b0}};
  reg  [31:0]      rdata_nxt;

  assign ev_now[`EV_IC_PERR]  = ic_ev;
  assign ev_now[`EV_DC_PERR]  = dc_ev;
  assign ev_now[`EV_TLB_PERR] = tl_ev;
  assign ev_now[`EV_BT_PERR]  = bt_ev;
  assign ev_now[`EV_IBUS_EXC] = ibus_ue & ~i_exc_busy;
  assign ev_now[`EV_DBUS_EXC] = dbus_ue & ~i_exc_busy;
  assign ev_now[`EV_HALT]     = halt_ev;
  assign o_irq = |(status_r & mask_r);

  always @* begin
    rdata_nxt = `WORD_RST;
    if (i_addr == `OFS_CTRL) begin
      rdata_nxt = {30'h0000_0000, ctrl_r};
    end else if (i_addr == `OFS_STATUS) begin
      rdata_nxt = {25'h000_0000, status_r};
    end else if (i_addr == `OFS_MASK) begin
      rdata_nxt = {25'h000_0000, mask_r};
    end else if (i_addr == `OFS_XLATE_UPPER) begin
      rdata_nxt = translation_upper_reg_r;
    end else if (i_addr == `OFS_XLATE_LOWER) begin
      rdata_nxt = translation_lower_reg_r;
    end else if (i_addr == `OFS_XLATE_INDEX) begin
      rdata_nxt = {{(32-TIDX_W){1'b0}}, xl_index_r};
    end
  end

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata                 <= `WORD_RST;
      ctrl_r                  <= `CTRL_RST;
      status_r                <= `STATUS_RST;
      mask_r                  <= `MASK_RST;
      translation_upper_reg_r <= `WORD_RST;
      translation_lower_reg_r <= `WORD_RST;
      xl_index_r              <= {TIDX_W{1'b0}};
    end else begin
      o_rdata  <= i_rd ? rdata_nxt : `WORD_RST;
      // a new event beats a clear in the same cycle
      status_r <= (status_r & ~st_clr) | ev_now;
      if (i_wr && i_addr == `OFS_CTRL) begin
        ctrl_r <= i_wdata[1:0];
      end
      if (i_wr && i_addr == `OFS_MASK) begin
        mask_r <= i_wdata[`EV_W-1:0];
      end
      if (i_wr && i_addr == `OFS_XLATE_INDEX) begin
        xl_index_r <= i_wdata[TIDX_W-1:0];
      end
      // read-back shows the entry with valid already cleared if corrupted
      if (tl_sw_rd) begin
        translation_upper_reg_r <= {tl_val_r[xl_index_r] & ~tl_rperr, {(31-VPN_W){1'b0}}, tl_vpn_r[xl_index_r]};
        translation_lower_reg_r <= {{(32-RPN_W){1'b0}}, tl_rpn_r[xl_index_r]};
      end else begin
        if (i_wr && i_addr == `OFS_XLATE_UPPER) begin
          translation_upper_reg_r <= i_wdata;
        end
        if (i_wr && i_addr == `OFS_XLATE_LOWER) begin
          translation_lower_reg_r <= i_wdata;
        end
      end
    end
  end

  // checks above are all gated by FT only
  // no controller ECC setting reaches this logic, so internal parity always stays on

endmodule

// [rtl/parity_guard_map.vh]
// Purpose: register offsets, field positions and reset values of the parity guard
// Assumes: 32-bit register port with byte addresses
// Notes:   included by its bare name
`ifndef PARITY_GUARD_MAP_VH
`define PARITY_GUARD_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_MASK        8'h08
`define OFS_XLATE_UPPER 8'h0c
`define OFS_XLATE_LOWER 8'h10
`define OFS_XLATE_INDEX 8'h14
`define OFS_XLATE_CMD   8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_WB_REQ_BIT 0
`define CTRL_TRAP_BIT   1
`define CMD_WRITE_BIT   0
`define CMD_READ_BIT    1
`define UPPER_VALID_BIT 31
`define EV_IC_PERR      0
`define EV_DC_PERR      1
`define EV_TLB_PERR     2
`define EV_BT_PERR      3
`define EV_IBUS_EXC     4
`define EV_DBUS_EXC     5
`define EV_HALT         6
`define EV_W            7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RST        2'h0
`define STATUS_RST      7'h00
`define MASK_RST        7'h00
`define WORD_RST        32'h0000_0000

`endif

// [rtl/parity_line.v]
// Purpose: even parity per word of a cache line, generated and checked
// Assumes: line packs word 0 in the lowest bits
// Notes:   purely combinational
`timescale 1ns/100ps

module parity_line #(
  parameter WORDS = 4,
  parameter DW    = 32
) (
  input  wire [WORDS*DW-1:0] i_line,
  input  wire [WORDS-1:0]    i_par,
  output wire [WORDS-1:0]    o_par,
  output wire [WORDS-1:0]    o_err
);

  genvar g;
  generate
    for (g = 0; g < WORDS; g = g + 1) begin : word
      // stored bit makes the word plus parity even
      assign o_par[g] = ^i_line[g*DW +: DW];
      assign o_err[g] = o_par[g] ^ i_par[g];
    end
  endgenerate

endmodule

// [test/parity_guard_asserts.sv]
// Purpose: temporal checks on the parity guard ports
// Assumes: one clock, asynchronous active-low reset
// Notes:   exception enable is mirrored from control writes
`timescale 1ns/100ps
`include "parity_guard_map.vh"
module parity_guard_asserts #(
  parameter FAULT_PROTECT_CFG = 1
) (
  input wire        i_sys_clk,
  input wire        i_arst_n,
  input wire [7:0]  i_addr,
  input wire [31:0] i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [31:0] o_rdata,
  input wire        o_dc_writeback,
  input wire        i_ic_look,
  input wire        o_ic_hit,
  input wire        i_tl_look,
  input wire        o_tl_hit,
  input wire        o_tl_miss_exc,
  input wire        i_ibus_ue,
  input wire        i_dbus_ue,
  input wire        i_exc_busy,
  input wire        o_ibus_exc,
  input wire        o_dbus_exc,
  input wire        o_halt_error_output
);
  reg  trap_r;
  wire en      = trap_r && (FAULT_PROTECT_CFG != 0);
  wire ibus_go = en && i_ibus_ue && !o_halt_error_output;
  wire dbus_go = en && i_dbus_ue && !o_halt_error_output;

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      trap_r <= 1'b0;
    else if (i_wr && i_addr == `OFS_CTRL)
      trap_r <= i_wdata[`CTRL_TRAP_BIT];
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  AST_WB_OFF: assert property ((FAULT_PROTECT_CFG != 0) |-> !o_dc_writeback)
    else $error("write-back offered while protected");
  AST_IBUS: assert property (ibus_go && !i_exc_busy |=> o_ibus_exc)
    else $error("instruction bus exception missing");
  AST_DBUS: assert property (dbus_go && !i_exc_busy |=> o_dbus_exc)
    else $error("data bus exception missing");
  AST_EE_OFF: assert property (!en |=> !o_ibus_exc && !o_dbus_exc)
    else $error("bus exception while disabled");
  AST_HALT_SET: assert property ((ibus_go || dbus_go) && i_exc_busy |=> o_halt_error_output)
    else $error("nested bus exception did not halt");
  AST_HALT_QUIET: assert property (o_halt_error_output |=> o_halt_error_output && !o_ibus_exc && !o_dbus_exc)
    else $error("halt dropped or exception after halt");
  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data outside read answer");
  AST_IC_CAUSE: assert property (o_ic_hit |-> $past(i_ic_look))
    else $error("cache hit without lookup");
  AST_TL_EXCL: assert property (o_tl_miss_exc |-> $past(i_tl_look) && !o_tl_hit)
    else $error("translation miss without lookup or with hit");

  cover property (o_ic_hit);
  cover property (o_tl_miss_exc);
  cover property ($rose(o_halt_error_output));
endmodule

// [test/ecc_ctrl_model.sv]
// Purpose: memory controller stand-in raising uncorrectable error flags
// Assumes: same clock as the guard
// Notes:   single-bit faults are corrected here and never reported
`timescale 1ns/100ps
module ecc_ctrl_model (
  input  wire i_sys_clk,
  input  wire i_arst_n,
  input  wire i_ecc_on,
  input  wire i_ifetch_bad,
  input  wire i_dload_bad,
  output reg  o_ibus_ue,
  output reg  o_dbus_ue
);
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ibus_ue <= 1'b0;
      o_dbus_ue <= 1'b0;
    end else begin
      o_ibus_ue <= i_ecc_on && i_ifetch_bad;
      o_dbus_ue <= i_ecc_on && i_dload_bad;
    end
  end
endmodule

// [test/parity_guard_test.sv]
// Purpose: directed scenarios for the parity guard
// Assumes: default parameters; arrays reachable for fault injection
// Notes:   faults are planted by hierarchical writes between edges
`timescale 1ns/100ps
`include "parity_guard_map.vh"
module parity_guard_test;
  reg          i_sys_clk   = 1'b0;
  reg          i_arst_n    = 1'b0;
  reg  [7:0]   i_addr      = 8'h00;
  reg  [31:0]  i_wdata     = 32'h0;
  reg          i_wr        = 1'b0;
  reg          i_rd        = 1'b0;
  reg  [9:0]   stb         = 10'h000;
  reg  [2:0]   i_ic_idx    = 3'h0;
  reg  [2:0]   i_dc_idx    = 3'h0;
  reg  [2:0]   i_tl_idx    = 3'h0;
  reg  [2:0]   i_bt_idx    = 3'h0;
  reg  [15:0]  i_ic_tag    = 16'h0;
  reg  [15:0]  i_dc_tag    = 16'h0;
  reg  [31:0]  i_ic_data   = 32'h0;
  reg  [31:0]  i_dc_wdata  = 32'h0;
  reg  [1:0]   i_dc_word   = 2'h0;
  reg  [127:0] i_dc_line   = 128'h0;
  reg  [19:0]  i_tl_vpn    = 20'h0;
  reg  [29:0]  i_bt_target = 30'h0;
  reg          i_exc_busy  = 1'b0;
  reg          ecc_on      = 1'b0;
  reg  [31:0]  rd;
  wire [31:0]  o_rdata, o_ic_data, o_dc_data;
  wire [19:0]  o_tl_rpn;
  wire [29:0]  o_bt_target;
  wire         o_irq, o_ic_hit, o_dc_hit, o_dc_writeback, o_tl_hit, o_tl_miss_exc, o_bt_valid;
  wire         o_ibus_exc, o_dbus_exc, o_halt_error_output, i_ibus_ue, i_dbus_ue;
  integer      fail_count  = 0;
  integer      check_count = 0;
  integer      cyc         = 0;

  parity_guard dut_u (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .i_ic_fill(stb[0]), .i_ic_look(stb[1]), .i_ic_idx(i_ic_idx), .i_ic_tag(i_ic_tag),
    .i_ic_data(i_ic_data), .o_ic_hit(o_ic_hit), .o_ic_data(o_ic_data),
    .i_dc_fill(stb[2]), .i_dc_store(stb[3]), .i_dc_look(stb[4]), .i_dc_idx(i_dc_idx),
    .i_dc_tag(i_dc_tag), .i_dc_word(i_dc_word), .i_dc_wdata(i_dc_wdata), .i_dc_line(i_dc_line),
    .o_dc_hit(o_dc_hit), .o_dc_data(o_dc_data), .o_dc_writeback(o_dc_writeback),
    .i_tl_look(stb[5]), .i_tl_idx(i_tl_idx), .i_tl_vpn(i_tl_vpn), .o_tl_hit(o_tl_hit),
    .o_tl_rpn(o_tl_rpn), .o_tl_miss_exc(o_tl_miss_exc), .i_bt_wr(stb[6]), .i_bt_look(stb[7]),
    .i_bt_idx(i_bt_idx), .i_bt_target(i_bt_target), .o_bt_valid(o_bt_valid),
    .o_bt_target(o_bt_target), .i_ibus_ue(i_ibus_ue), .i_dbus_ue(i_dbus_ue),
    .i_exc_busy(i_exc_busy), .o_ibus_exc(o_ibus_exc), .o_dbus_exc(o_dbus_exc),
    .o_halt_error_output(o_halt_error_output)
  );

  ecc_ctrl_model mdl_u (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_ecc_on(ecc_on), .i_ifetch_bad(stb[8]),
    .i_dload_bad(stb[9]), .o_ibus_ue(i_ibus_ue), .o_dbus_ue(i_dbus_ue)
  );

  always #25 i_sys_clk = ~i_sys_clk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input [127:0] got, input [127:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
    end
  endtask

  // strobes last one cycle; results are sampled once the answering edge has landed
  task go(input [9:0] s);
    begin
      @(posedge i_sys_clk);
      stb <= s;
      @(posedge i_sys_clk);
      stb <= 10'h000;
      #1;
    end
  endtask

  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= w;
      i_rd <= !w;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      #1 rd = o_rdata;
    end
  endtask

  task fin(input string n);
    $display("test %s done", n);
  endtask

  task stop_test;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_icache;
    begin
      i_ic_idx <= 3'h3;
      i_ic_tag <= 16'ha5c3;
      i_ic_data <= 32'h0f0f_1234;
      go(10'h001);
      go(10'h002);
      chk({o_ic_hit, o_ic_data}, {1'b1, 32'h0f0f_1234});
      dut_u.ic_dat_r[3] = dut_u.ic_dat_r[3] ^ 32'h0000_0100;
      go(10'h002);
      chk(o_ic_hit, 1'b0);
      chk(o_irq, 1'b0);
      xfer(1, `OFS_MASK, 32'h1);
      chk(o_irq, 1'b1);
      xfer(0, `OFS_STATUS, 32'h0);
      chk(rd, 32'h1);
      go(10'h002);
      chk(o_ic_hit, 1'b0);
      xfer(1, `OFS_STATUS, 32'h1);
      chk(o_irq, 1'b0);
      xfer(1, `OFS_MASK, 32'h0);
      go(10'h001);
      go(10'h002);
      chk(o_ic_hit, 1'b1);
      fin("icache");
    end
  endtask

  task t_dcache;
    begin
      i_dc_idx <= 3'h5;
      i_dc_tag <= 16'h0c3a;
      i_dc_line <= 128'h4444_4444_3333_3333_2222_2222_1111_1111;
      i_dc_word <= 2'h2;
      i_dc_wdata <= 32'hcafe_0002;
      go(10'h004);
      go(10'h008);
      go(10'h010);
      chk({o_dc_hit, o_dc_data}, {1'b1, 32'hcafe_0002});
      dut_u.dc_line_r[5] = dut_u.dc_line_r[5] ^ (128'h1 << 32);
      i_dc_word <= 2'h1;
      go(10'h010);
      chk(o_dc_hit, 1'b0);
      xfer(0, `OFS_STATUS, 32'h0);
      chk(rd, 32'h2);
      xfer(1, `OFS_STATUS, 32'h2);
      fin("dcache");
    end
  endtask

  task t_tlb;
    begin
      xfer(1, `OFS_XLATE_UPPER, 32'h8001_2345);
      xfer(1, `OFS_XLATE_LOWER, 32'h000a_bcde);
      xfer(1, `OFS_XLATE_INDEX, 32'h2);
      xfer(1, `OFS_XLATE_CMD, 32'h1);
      i_tl_idx <= 3'h2;
      i_tl_vpn <= 20'h12345;
      go(10'h020);
      chk({o_tl_hit, o_tl_miss_exc, o_tl_rpn}, {2'b10, 20'habcde});
      dut_u.tl_rpn_r[2] = dut_u.tl_rpn_r[2] ^ 20'h00001;
      go(10'h020);
      chk({o_tl_hit, o_tl_miss_exc}, 2'b01);
      xfer(1, `OFS_XLATE_UPPER, 32'h0);
      xfer(1, `OFS_XLATE_CMD, 32'h2);
      xfer(0, `OFS_XLATE_UPPER, 32'h0);
      chk(rd, 32'h0001_2345);
      xfer(0, `OFS_STATUS, 32'h0);
      chk(rd, 32'h4);
      xfer(1, `OFS_STATUS, 32'h4);
      fin("tlb");
    end
  endtask

  task t_bt;
    begin
      i_bt_idx <= 3'h1;
      i_bt_target <= 30'h1234_5678;
      go(10'h040);
      go(10'h080);
      chk({o_bt_valid, o_bt_target}, {1'b1, 30'h1234_5678});
      dut_u.bt_tgt_r[1] = dut_u.bt_tgt_r[1] ^ 30'h4;
      go(10'h080);
      chk(o_bt_valid, 1'b0);
      xfer(0, `OFS_STATUS, 32'h0);
      chk(rd, 32'h8);
      xfer(1, `OFS_STATUS, 32'h8);
      fin("branch");
    end
  endtask

  // halting is sticky until reset, so this runs last
  task t_bus;
    begin
      ecc_on <= 1'b1;
      xfer(1, `OFS_CTRL, 32'h3);
      chk(o_dc_writeback, 1'b0);
      xfer(0, 8'hfc, 32'h0);
      chk(rd, 32'h0);
      xfer(1, `OFS_CTRL, 32'h0);
      go(10'h200);
      @(posedge i_sys_clk);
      #1 chk(o_dbus_exc, 1'b0);
      xfer(1, `OFS_CTRL, 32'h2);
      go(10'h200);
      @(posedge i_sys_clk);
      #1 chk(o_dbus_exc, 1'b1);
      go(10'h100);
      @(posedge i_sys_clk);
      #1 chk(o_ibus_exc, 1'b1);
      xfer(0, `OFS_STATUS, 32'h0);
      chk(rd, 32'h30);
      i_exc_busy <= 1'b1;
      go(10'h200);
      @(posedge i_sys_clk);
      #1 chk({o_halt_error_output, o_dbus_exc}, 2'b10);
      go(10'h000);
      chk(o_halt_error_output, 1'b1);
      fin("bus");
    end
  endtask

  always @(posedge i_sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fail_count = fail_count + 1;
      stop_test;
    end
  end

  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    t_icache;
    t_dcache;
    t_tlb;
    t_bt;
    t_bus;
    stop_test;
  end
endmodule

bind parity_guard parity_guard_asserts #(.FAULT_PROTECT_CFG(FAULT_PROTECT_CFG)) chk_u (
  .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_dc_writeback(o_dc_writeback),
  .i_ic_look(i_ic_look), .o_ic_hit(o_ic_hit), .i_tl_look(i_tl_look), .o_tl_hit(o_tl_hit),
  .o_tl_miss_exc(o_tl_miss_exc), .i_ibus_ue(i_ibus_ue), .i_dbus_ue(i_dbus_ue),
  .i_exc_busy(i_exc_busy), .o_ibus_exc(o_ibus_exc), .o_dbus_exc(o_dbus_exc),
  .o_halt_error_output(o_halt_error_output)
);
